/* File: common/sadc_pkg.sv */
// shared constants, field layouts and carrier types for the converter control block
package sadc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_PRESCALE   = 8'h94;
  localparam logic [7:0] IDX_RESULT_LO  = 8'h95;
  localparam logic [7:0] IDX_RESULT_HI  = 8'h96;
  localparam logic [7:0] IDX_CONTROL    = 8'h97;

  localparam logic [11:0] ADDR_PRESCALE  = {2'b00, IDX_PRESCALE, 2'b00};
  localparam logic [11:0] ADDR_RESULT_LO = {2'b00, IDX_RESULT_LO, 2'b00};
  localparam logic [11:0] ADDR_RESULT_HI = {2'b00, IDX_RESULT_HI, 2'b00};
  localparam logic [11:0] ADDR_CONTROL   = {2'b00, IDX_CONTROL, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // control/status bit positions
  localparam int BIT_IRQ_FLAG = 7;
  localparam int BIT_IRQ_EN   = 6;
  localparam int BIT_POWER    = 5;
  localparam int BIT_CHAN_HI  = 4;
  localparam int BIT_CHAN_LO  = 2;
  localparam int BIT_START    = 1;
  localparam int BIT_DONE     = 0;

  // prescaler bit positions
  localparam int BIT_REF_GATE = 3;
  localparam int BIT_DIV_HI   = 2;
  localparam int BIT_DIV_LO   = 0;

  // result split between the two result registers
  localparam int RES_LO_HI    = 7;
  localparam int RES_HI_HI    = 9;
  localparam int RES_HI_LO    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RESET_CONTROL  = 8'h00;
  localparam logic [3:0] RESET_PRESCALE = 4'h0;
  localparam logic [9:0] RESET_RESULT   = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       conv_done_irq_flag;
    logic       conv_irq_enable;
    logic       converter_power_enable;
    logic [2:0] channel_select;
    logic       start_trigger_bit;
    logic       conv_done_status;
  } sadc_control_type;

  typedef struct packed {
    logic       ref_clock_gate;
    logic [2:0] ref_clock_divide_field;
  } sadc_prescale_type;

  // what the sequencer reports back to the register file
  typedef struct packed {
    logic       busy;
    logic       done_set;
    logic [9:0] result;
  } sadc_seq_report_type;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_BUSY = 3'b010,
    SEQ_LOAD = 3'b100
  } sadc_seq_state_type;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PRESCALE,
    SEL_RESULT_LO,
    SEL_RESULT_HI,
    SEL_CONTROL
  } sadc_sel_type;

endpackage

/* File: hdl/sadc_refclk_div.sv */
// power-of-two divider producing the converter reference clock strobe
`timescale 1ns/1ps
`default_nettype none

module sadc_refclk_div
  import sadc_pkg::*;
#(
  parameter int DIV_WIDTH = 3
)
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 gate,
  input  wire logic [DIV_WIDTH-1:0] divide,
  output logic                      tick
);

  localparam int CNT_W = (1 << DIV_WIDTH) - 1;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } sadc_div_reg_type;

  sadc_div_reg_type st;
  sadc_div_reg_type next_st;

  function automatic logic [CNT_W-1:0] div_mask(input logic [DIV_WIDTH-1:0] n);
    logic [CNT_W:0] one_hot;
    one_hot = '0;
    one_hot[n] = 1'b1;
    div_mask = CNT_W'(one_hot - 1'b1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    if (!gate)
    begin
      // gated off: counter parked so the first tick after enable is a full period
      next_st.count = '0;
      next_st.tick  = 1'b0;
    end
    else
    begin
      next_st.tick  = ((st.count & div_mask(divide)) == div_mask(divide));
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule

`default_nettype wire

/* File: hdl/sadc_conv_seq.sv */
// conversion sequencer: start handshake toward the analog core and result capture
`timescale 1ns/1ps
`default_nettype none

module sadc_conv_seq
  import sadc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start_req,
  input  wire logic          power_on,
  input  wire logic          conv_done,
  input  wire logic [9:0]    conv_result,
  output logic               start_pulse,
  output sadc_seq_report_type report
);

  typedef struct packed {
    sadc_seq_state_type state;
    logic               start_pulse;
    logic               done_set;
    logic [9:0]         result;
  } sadc_seq_reg_type;

  localparam sadc_seq_reg_type SEQ_RESET = '{
    state:       SEQ_IDLE,
    start_pulse: 1'b0,
    done_set:    1'b0,
    result:      RESET_RESULT
  };

  sadc_seq_reg_type st;
  sadc_seq_reg_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.start_pulse = 1'b0;
    next_st.done_set    = 1'b0;
    case (st.state)
      SEQ_IDLE:
      begin
        // a start with the converter powered down is dropped
        if (start_req && power_on)
        begin
          next_st.start_pulse = 1'b1;
          next_st.state       = SEQ_BUSY;
        end
      end
      SEQ_BUSY:
      begin
        if (!power_on)
          next_st.state = SEQ_IDLE;
        else if (conv_done)
        begin
          next_st.result = conv_result;
          next_st.state  = SEQ_LOAD;
        end
      end
      SEQ_LOAD:
      begin
        // status follows one cycle after the result is in place
        next_st.done_set = 1'b1;
        next_st.state    = SEQ_IDLE;
      end
      default:
      begin
        next_st.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= SEQ_RESET;
    else
      st <= next_st;
  end

  assign start_pulse     = st.start_pulse;
  assign report.busy     = (st.state == SEQ_BUSY);
  assign report.done_set = st.done_set;
  assign report.result   = st.result;

endmodule

`default_nettype wire

/* File: hdl/sadc_ctrl_regs.sv */
// register file and control for the eight-channel 10-bit converter, APB slave
//
// Overview of operation
// - flag sets on each rising edge of the done status bit
// - interrupt request asserted only while flag and enable are both one
// - power enable zero shuts converter off; one enables it
// - three-bit channel field picks analog input 0 through 7
// - writing one to start begins conversion; bit self-clears next cycle
// - done status reads zero until conversion completes, then one
// - software may clear done status by writing zero
// - prescaler bit 3 gates reference clock; off at reset
// - reference clock is oscillator divided by two to the prescale field
// - low result register holds result bits 7 to 0
// - high result register holds bits 9 and 8 in low bits
// - all four registers reset to zero
// - completion loads result first, then sets done status
// - done status is cleared while a conversion runs
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module sadc_ctrl_regs
  import sadc_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int DIV_WIDTH  = 3
)
(
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [ADDR_WIDTH-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic                       PREADY,
  output logic [31:0]                PRDATA,
  output logic                       PSLVERR,
  input  wire logic                  CONV_DONE,
  input  wire logic [9:0]            CONV_RESULT,
  output logic                       CONVERTER_POWER_ENABLE,
  output logic [2:0]                 CHANNEL_SELECT,
  output logic                       CONV_START,
  output logic                       CONVERTER_REF_CLOCK,
  output logic                       CONV_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sadc_control_type  control;
    sadc_prescale_type prescale;
    logic              done_prev;
    logic              irq;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
  } sadc_top_reg_type;

  localparam sadc_top_reg_type TOP_RESET = '{
    control:   sadc_control_type'(RESET_CONTROL),
    prescale:  sadc_prescale_type'(RESET_PRESCALE),
    done_prev: 1'b0,
    irq:       1'b0,
    pready:    1'b0,
    prdata:    32'h0000_0000,
    pslverr:   1'b0
  };

  sadc_top_reg_type    st;
  sadc_top_reg_type    next_st;
  sadc_seq_report_type report;
  logic                start_pulse;
  logic                ref_tick;
  sadc_sel_type        sel;
  logic                access;
  logic                wr;
  logic [31:0]         rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // address decode; any address off the four words, misaligned included, is unmapped
  function automatic sadc_sel_type decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    if (ADDR_WIDTH > 12 && (addr >> 12) != '0)
      decode = SEL_NONE;
    else if (a == ADDR_PRESCALE)
      decode = SEL_PRESCALE;
    else if (a == ADDR_RESULT_LO)
      decode = SEL_RESULT_LO;
    else if (a == ADDR_RESULT_HI)
      decode = SEL_RESULT_HI;
    else if (a == ADDR_CONTROL)
      decode = SEL_CONTROL;
    else
      decode = SEL_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sadc_conv_seq u_seq (
    .clk         (MCLK),
    .rst         (RESET),
    .start_req   (st.control.start_trigger_bit),
    .power_on    (st.control.converter_power_enable),
    .conv_done   (CONV_DONE),
    .conv_result (CONV_RESULT),
    .start_pulse (start_pulse),
    .report      (report)
  );

  sadc_refclk_div #(
    .DIV_WIDTH (DIV_WIDTH)
  ) u_div (
    .clk    (MCLK),
    .rst    (RESET),
    .gate   (st.prescale.ref_clock_gate),
    .divide (DIV_WIDTH'(st.prescale.ref_clock_divide_field)),
    .tick   (ref_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reads are free of side effects so polling never loses a result
  always_comb
  begin
    sel = decode(PADDR);
    case (sel)
      SEL_CONTROL:
        rd_data = {24'h000000, st.control};
      SEL_PRESCALE:
        rd_data = {28'h0000000, st.prescale};
      SEL_RESULT_LO:
        rd_data = {24'h000000, report.result[RES_LO_HI:0]};
      SEL_RESULT_HI:
        rd_data = {30'h00000000, report.result[RES_HI_HI:RES_HI_LO]};
      default:
        rd_data = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    access  = PSEL && PENABLE && st.pready;
    wr      = access && PWRITE && PSTRB[0];

    // start bit is one cycle wide whatever was written
    next_st.control.start_trigger_bit = 1'b0;
    next_st.done_prev = st.control.conv_done_status;

    // bus: answer is prepared in the setup cycle, no wait states
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    if (PSEL && !PENABLE)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = (sel == SEL_NONE);
      next_st.prdata  = PWRITE ? 32'h0000_0000 : rd_data;
    end

    // software writes; result registers are read-only and ignore writes
    if (wr && sel == SEL_CONTROL)
    begin
      next_st.control.conv_irq_enable = PWDATA[BIT_IRQ_EN];
      next_st.control.converter_power_enable = PWDATA[BIT_POWER];
      next_st.control.channel_select = PWDATA[BIT_CHAN_HI:BIT_CHAN_LO];
      if (!PWDATA[BIT_IRQ_FLAG])
        next_st.control.conv_done_irq_flag = 1'b0;
      if (PWDATA[BIT_START])
        next_st.control.start_trigger_bit = 1'b1;
      if (!PWDATA[BIT_DONE])
        next_st.control.conv_done_status = 1'b0;
    end
    if (wr && sel == SEL_PRESCALE)
    begin
      next_st.prescale.ref_clock_gate = PWDATA[BIT_REF_GATE];
      next_st.prescale.ref_clock_divide_field = PWDATA[BIT_DIV_HI:BIT_DIV_LO];
    end

    // hardware updates come after software so a set beats a same-cycle clear
    if (report.busy)
      next_st.control.conv_done_status = 1'b0;
    if (report.done_set)
      next_st.control.conv_done_status = 1'b1;
    if (st.control.conv_done_status && !st.done_prev)
      next_st.control.conv_done_irq_flag = 1'b1;

    next_st.irq = next_st.control.conv_done_irq_flag
                  && next_st.control.conv_irq_enable;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      st <= TOP_RESET;
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign PREADY                 = st.pready;
  assign PRDATA                 = st.prdata;
  assign PSLVERR                = st.pslverr;
  assign CONVERTER_POWER_ENABLE = st.control.converter_power_enable;
  assign CHANNEL_SELECT         = st.control.channel_select;
  assign CONV_START             = start_pulse;
  assign CONVERTER_REF_CLOCK    = ref_tick;
  assign CONV_IRQ               = st.irq;

endmodule

`default_nettype wire

/* File: dv/sadc_ctrl_regs_sva.sv */
// assertion checker for the converter control register block
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_regs_sva
  import sadc_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int DIV_WIDTH  = 3
)
(
  input wire logic                  MCLK,
  input wire logic                  RESET,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [ADDR_WIDTH-1:0] PADDR,
  input wire logic [31:0]           PWDATA,
  input wire logic [3:0]            PSTRB,
  input wire logic                  PREADY,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PSLVERR,
  input wire logic                  CONVERTER_POWER_ENABLE,
  input wire logic [2:0]            CHANNEL_SELECT,
  input wire logic                  CONV_START,
  input wire logic                  CONVERTER_REF_CLOCK,
  input wire logic                  CONV_IRQ
);
  logic       acc;
  logic       wr_ctrl;
  logic       wr_pre;
  logic       st_wr;
  logic       mapped;
  logic       en_sh;
  logic       gate_sh;
  logic [2:0] div_sh;
  logic [1:0] seen;
  logic [7:0] gap;

  assign acc = PSEL && PENABLE && PREADY;
  assign wr_ctrl = acc && PWRITE && PSTRB[0] && PADDR == ADDR_CONTROL;
  assign wr_pre = acc && PWRITE && PSTRB[0] && PADDR == ADDR_PRESCALE;
  assign st_wr = wr_ctrl && PWDATA[1];
  assign mapped = PADDR inside {ADDR_PRESCALE, ADDR_RESULT_LO, ADDR_RESULT_HI, ADDR_CONTROL};

  ////////////////////////////////////////////////////////////////////////////
  // shadows of enable, gate and divide; strobe spacing is only trusted two strobes after a write
  always_ff @(posedge MCLK)
  begin
    if (RESET || wr_pre)
    begin
      seen <= 2'h0;
    end
    else if (CONVERTER_REF_CLOCK && seen != 2'h2)
    begin
      seen <= seen + 2'h1;
    end
    if (RESET)
    begin
      en_sh <= 1'b0;
      gate_sh <= 1'b0;
      div_sh <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        en_sh <= PWDATA[6];
      if (wr_pre)
        gate_sh <= PWDATA[3];
      if (wr_pre)
        div_sh <= PWDATA[2:0];
    end
    gap <= CONVERTER_REF_CLOCK ? 8'h00 : gap + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  AST_READY_ZERO_WAIT:
    assert property (PSEL && !PENABLE |=> PREADY) else $error("access not answered at once");
  AST_READY_ONE_CYCLE:
    assert property (PREADY |=> !PREADY) else $error("ready held too long");
  AST_ERR_UNMAPPED:
    assert property (acc |-> PSLVERR == !mapped) else $error("error flag wrong for address");
  AST_HIGH_RESERVED:
    assert property (acc && !PWRITE && PADDR == ADDR_RESULT_HI |-> PRDATA[31:2] == 30'h0)
    else $error("high result upper bits not zero");
  AST_START_PULSE:
    assert property (CONV_START |=> !CONV_START) else $error("start pulse too long");
  AST_START_CAUSE:
    assert property ($rose(CONV_START) |-> $past(st_wr, 2) || $past(st_wr, 3))
    else $error("start without start write");
  AST_START_POWER:
    assert property (CONV_START |-> CONVERTER_POWER_ENABLE) else $error("start while unpowered");
  AST_CTRL_PINS:
    assert property (wr_ctrl |-> ##2 (CHANNEL_SELECT == $past(PWDATA[4:2], 2)
      && CONVERTER_POWER_ENABLE == $past(PWDATA[5], 2))) else $error("channel or power pin stale");
  AST_REF_GATED:
    assert property (!gate_sh && !$past(wr_pre) && !$past(wr_pre, 2) |-> !CONVERTER_REF_CLOCK)
    else $error("reference strobe while gated");
  AST_REF_PERIOD:
    assert property (CONVERTER_REF_CLOCK && seen == 2'h2 |-> gap == (8'h01 << div_sh) - 8'h01)
    else $error("reference period wrong");
  AST_IRQ_ENABLE:
    assert property (CONV_IRQ |-> en_sh || $past(en_sh)) else $error("request while disabled");
endmodule

bind sadc_ctrl_regs sadc_ctrl_regs_sva #(.ADDR_WIDTH(ADDR_WIDTH), .DIV_WIDTH(DIV_WIDTH))
  sadc_ctrl_regs_sva_inst (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CONVERTER_POWER_ENABLE(CONVERTER_POWER_ENABLE),
  .CHANNEL_SELECT(CHANNEL_SELECT), .CONV_START(CONV_START),
  .CONVERTER_REF_CLOCK(CONVERTER_REF_CLOCK), .CONV_IRQ(CONV_IRQ));
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the converter control register block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sadc_pkg::*;
;
  logic        MCLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, CONV_DONE = 0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, q;
  logic [3:0]  PSTRB = 4'h1;
  logic [9:0]  CONV_RESULT = '0;
  logic [2:0]  CHANNEL_SELECT;
  logic        PREADY, PSLVERR, CONVERTER_POWER_ENABLE, CONV_START, CONVERTER_REF_CLOCK;
  logic        CONV_IRQ, e;
  int          err_count = 0, check_count = 0, i;

  always #4 MCLK = ~MCLK;

  sadc_ctrl_regs sadc_ctrl_regs_inst (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CONV_DONE(CONV_DONE),
    .CONV_RESULT(CONV_RESULT), .CONVERTER_POWER_ENABLE(CONVERTER_POWER_ENABLE),
    .CHANNEL_SELECT(CHANNEL_SELECT), .CONV_START(CONV_START),
    .CONVERTER_REF_CLOCK(CONVERTER_REF_CLOCK), .CONV_IRQ(CONV_IRQ));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one transfer; waits for ready under a bound and latches data and error at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic got;
    got = 0;
    @(posedge MCLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 16 && !got; n++)
    begin
      @(posedge MCLK);
      got = (PREADY === 1'b1);
    end
    q = PRDATA;
    e = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
    if (!got)
    begin
      err_count++;
      $display("BAD %0t no ready", $time);
      conclude();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask

  task automatic wait_start(input logic exp);
    int   n;
    logic s;
    s = 0;
    for (n = 0; n < 8 && !s; n++)
    begin
      @(posedge MCLK);
      s = (CONV_START === 1'b1);
    end
    chk({31'h0, s}, {31'h0, exp}, "start pulse");
  endtask

  // analog core reports completion; result line is scrambled once the pulse is over
  task automatic finish_conv(input logic [9:0] r);
    @(posedge MCLK);
    {CONV_DONE, CONV_RESULT} <= {1'b1, r};
    @(posedge MCLK);
    {CONV_DONE, CONV_RESULT} <= {1'b0, ~r};
    repeat (8) @(posedge MCLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    rd(ADDR_PRESCALE, 32'h0, "prescale reset");
    rd(ADDR_RESULT_LO, 32'h0, "low reset");
    rd(ADDR_RESULT_HI, 32'h0, "high reset");
    rd(ADDR_CONTROL, 32'h0, "control reset");
    rd(12'h260, 32'h0, "unmapped read");
    chk({31'h0, e}, 32'h1, "unmapped error");
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, ADDR_PRESCALE, 32'h8 | i);
      rd(ADDR_PRESCALE, 32'h8 | i, "prescale");
      repeat (4 << i) @(posedge MCLK);
    end
    apb(1'b1, ADDR_PRESCALE, 32'h3);
    repeat (20) @(posedge MCLK);
    chk({31'h0, CONVERTER_REF_CLOCK}, 32'h0, "gated strobe");
    $display("test prescaler done");
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, ADDR_CONTROL, 32'h20 | (i << 2));
      rd(ADDR_CONTROL, 32'h20 | (i << 2), "control");
      chk({29'h0, CHANNEL_SELECT}, i, "channel pins");
      chk({31'h0, CONVERTER_POWER_ENABLE}, 32'h1, "power pin");
    end
    apb(1'b1, ADDR_RESULT_LO, 32'hff);
    rd(ADDR_RESULT_LO, 32'h0, "result read only");
    PSTRB <= 4'h0;
    apb(1'b1, ADDR_CONTROL, 32'h0);
    PSTRB <= 4'h1;
    rd(ADDR_CONTROL, 32'h3c, "no strobe write");
    apb(1'b1, ADDR_CONTROL, 32'h02);
    wait_start(1'b0);
    rd(ADDR_CONTROL, 32'h0, "start self clear");
    $display("test control done");
    apb(1'b1, ADDR_CONTROL, 32'h74);
    apb(1'b1, ADDR_CONTROL, 32'h76);
    wait_start(1'b1);
    finish_conv(10'h2a5);
    rd(ADDR_CONTROL, 32'hf5, "done and flag");
    chk({31'h0, CONV_IRQ}, 32'h1, "irq raised");
    rd(ADDR_RESULT_LO, 32'ha5, "low result");
    rd(ADDR_RESULT_HI, 32'h02, "high result");
    rd(ADDR_CONTROL, 32'hf5, "reads no side effect");
    apb(1'b1, ADDR_CONTROL, 32'hf7);
    wait_start(1'b1);
    rd(ADDR_CONTROL, 32'hf4, "status low while busy");
    finish_conv(10'h15a);
    rd(ADDR_RESULT_LO, 32'h5a, "low result 2");
    rd(ADDR_RESULT_HI, 32'h01, "high result 2");
    apb(1'b1, ADDR_CONTROL, 32'hb5);
    repeat (2) @(posedge MCLK);
    chk({31'h0, CONV_IRQ}, 32'h0, "irq masked");
    apb(1'b1, ADDR_CONTROL, 32'h34);
    rd(ADDR_CONTROL, 32'h34, "software clear");
    $display("test conversion done");
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge MCLK);
    err_count++;
    $display("BAD %0t timeout", $time);
    conclude();
  end
endmodule
`default_nettype wire
